// ===== common/fhr_pkg.sv
// constants, register map and carrier types for the fan hysteresis and ramp block
package fhr_pkg;

    // ****************************************
    // clock and time base
    // ****************************************
    localparam int CLK_PERIOD_NS = 100;                 // 10 MHz system clock
    localparam int SLOT_NS = 10000;                     // length of one pwm time slot
    localparam int SLOT_CYC = (SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLOT_CNT_W = 8;                      // width of the slot prescaler
    localparam logic [SLOT_CNT_W-1:0] SLOT_LAST = SLOT_CNT_W'(SLOT_CYC - 1);
    localparam logic [7:0] SLOTS_LAST = 8'hFE;          // 255 slots per period: 0..254

    // ****************************************
    // register indices (byte address = 4 x index)
    // ****************************************
    localparam logic [7:0] IDX_DUTY_A = 8'h30;          // live duty, read only
    localparam logic [7:0] IDX_DUTY_B = 8'h31;
    localparam logic [7:0] IDX_DUTY_C = 8'h32;
    localparam logic [7:0] IDX_ACOUSTIC_ONE = 8'h62;
    localparam logic [7:0] IDX_ACOUSTIC_TWO = 8'h63;
    localparam logic [7:0] IDX_FLOOR_A = 8'h64;
    localparam logic [7:0] IDX_FLOOR_B = 8'h65;
    localparam logic [7:0] IDX_FLOOR_C = 8'h66;
    localparam logic [7:0] IDX_HYST_R1_LOC = 8'h6D;
    localparam logic [7:0] IDX_HYST_R2 = 8'h6E;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] ACOUSTIC_RST = 8'h00;
    localparam logic [7:0] FLOOR_RST = 8'h80;
    localparam logic [7:0] HYST_R1_LOC_RST = 8'h44;
    localparam logic [7:0] HYST_R2_RST = 8'h40;
    localparam logic [7:0] DUTY_RST = 8'hFF;
    localparam logic [7:0] DUTY_FULL = 8'hFF;
    localparam logic [7:0] DUTY_OFF = 8'h00;
    localparam logic [7:0] CRIT_HYST = 8'h04;           // fixed critical-limit hysteresis
    localparam logic [3:0] HYST_RSVD_MASK = 4'h0;       // reserved nibble reads zero

    // ****************************************
    // field positions
    // ****************************************
    localparam int HOLD_A_BIT = 5;
    localparam int HOLD_B_BIT = 6;
    localparam int HOLD_C_BIT = 7;
    localparam int RAMP_EN_A_BIT = 3;                   // in acoustic_ctrl_one
    localparam int RAMP_EN_B_BIT = 7;                   // in acoustic_ctrl_two
    localparam int RAMP_EN_C_BIT = 3;                   // in acoustic_ctrl_two
    localparam int RATE_A_LSB = 0;
    localparam int RATE_B_LSB = 4;
    localparam int RATE_C_LSB = 0;
    localparam int HYST_HI_LSB = 4;
    localparam int HYST_LO_LSB = 0;

    // ramp step in slots, indexed by the 3-bit rate code
    localparam logic [7:0][7:0] RAMP_STEP_LUT = {8'h30, 8'h18, 8'h0C, 8'h08, 8'h05, 8'h03, 8'h02, 8'h01};

    // ****************************************
    // carrier types
    // ****************************************
    typedef logic [1:0] fhr_src_t;                      // 0 remote one, 1 local, 2 remote two

    typedef struct packed {
        logic [7:0] temp;                               // latest reading, whole degrees
        logic [7:0] fan_on_temp;                        // turn-on point of the channel
        logic [7:0] crit_limit;                         // critical_limit of the channel
        logic update;                                   // one-cycle pulse: new reading
    } fhr_chan_s;

endpackage : fhr_pkg

// ===== hw/fhr_fan_ctrl.sv
// fan drive: turn-off hysteresis, floor hold, acoustic ramp and pwm for three outputs
//
// What this block does
// R1 - per-channel hysteresis, four bits, default four degrees
// R2 - first hysteresis register: remote one high, local low
// R3 - second hysteresis register: remote two in high nibble
// R4 - hold bit clear: output off below hysteresis point
// R5 - hold bit set: output runs at floor_duty
// R6 - no smoothing: new duty applied at once
// R7 - acoustic one bit 3 enables ramp on a
// R8 - acoustic two bits 7, 3 enable b, c
// R9 - each output ramps independently of the others
// R10 - period is 255 slots; high time = duty
// R11 - target above previous: raise by selected step
// R12 - target below previous: lower by selected step
// R13 - result kept as previous for next compare
// R14 - rate a code maps to 1..48 slots
// R15 - rate c in acoustic two bits 2:0
// R16 - rate b in acoustic two bits 6:4
// R17 - full swing about 35 s down to 0.8 s
// R18 - software should disable spin-up while ramping
// R19 - eight-bit floor_duty register per output
// R20 - over critical_limit all fans full until four below
// R21 - step never overshoots; equal target holds duty
// R22 - one ramp step per new reading of source
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ns
module fhr_fan_ctrl
    import fhr_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // avalon-mm slave, byte address, 32-bit data
    input wire logic [9:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // temperature channels and computed targets, same clock domain
    input wire fhr_chan_s [2:0] chan_i,
    input wire fhr_src_t [2:0] src_sel_i,
    input wire logic [2:0][7:0] target_duty_i,
    // fan drive
    output logic fan_out_a_o,
    output logic fan_out_b_o,
    output logic fan_out_c_o,
    output logic [2:0] crit_active_o
);

    // ****************************************
    // register file
    // ****************************************
    logic [7:0] acoustic_ctrl_one_reg;           // hold bits, ramp a enable and rate
    logic [7:0] acoustic_ctrl_two_reg;           // ramp b and c enables and rates
    logic [7:0] hyst_r1_loc_reg;                 // remote one and local hysteresis
    logic [3:0] hyst_r2_reg;                     // remote two hysteresis, upper nibble only
    logic [2:0][7:0] floor_duty_reg;             // per-output floor duty
    logic ack_reg;                               // answer phase of a bus request
    logic [31:0] rdata_reg;                      // registered read data

    // per-output live duty and pwm state
    logic [2:0][7:0] duty_reg;                   // previous duty, also drives the pwm
    logic [2:0] fan_pin_reg;                     // registered pwm pins
    logic [SLOT_CNT_W-1:0] prescale_reg;         // cycles inside one slot
    logic [7:0] slot_reg;                        // slot index inside the period

    // per-channel state
    logic [2:0] below_off_reg;                   // channel sits below its turn-off point
    logic [2:0] crit_reg;                        // channel over its critical limit

    // ****************************************
    // bus decode
    // ****************************************
    wire [7:0] reg_idx = avs_address_i[9:2];
    wire bus_req = avs_read_i | avs_write_i;
    // a single wait state: the request is seen, then answered on the next edge
    wire bus_ack = bus_req & ack_reg;
    wire wr_low = bus_ack & avs_write_i & avs_byteenable_i[0];
    wire [7:0] wr_byte = avs_writedata_i[7:0];

    wire hit_duty_a = reg_idx == IDX_DUTY_A;
    wire hit_duty_b = reg_idx == IDX_DUTY_B;
    wire hit_duty_c = reg_idx == IDX_DUTY_C;
    wire hit_ac_one = reg_idx == IDX_ACOUSTIC_ONE;
    wire hit_ac_two = reg_idx == IDX_ACOUSTIC_TWO;
    wire hit_floor_a = reg_idx == IDX_FLOOR_A;
    wire hit_floor_b = reg_idx == IDX_FLOOR_B;
    wire hit_floor_c = reg_idx == IDX_FLOOR_C;
    wire hit_hyst_one = reg_idx == IDX_HYST_R1_LOC;
    wire hit_hyst_two = reg_idx == IDX_HYST_R2;

    // read mux; unmapped words read as zero and writes to them are dropped
    wire [7:0] rd_byte =
        hit_duty_a ? duty_reg[0] :
        hit_duty_b ? duty_reg[1] :
        hit_duty_c ? duty_reg[2] :
        hit_ac_one ? acoustic_ctrl_one_reg :
        hit_ac_two ? acoustic_ctrl_two_reg :
        hit_floor_a ? floor_duty_reg[0] :
        hit_floor_b ? floor_duty_reg[1] :
        hit_floor_c ? floor_duty_reg[2] :
        hit_hyst_one ? hyst_r1_loc_reg :
        hit_hyst_two ? {hyst_r2_reg, HYST_RSVD_MASK} :
        DUTY_OFF;

    assign avs_waitrequest_o = bus_req & ~ack_reg;
    assign avs_readdata_o = rdata_reg;

    // ****************************************
    // field extraction
    // ****************************************
    wire [2:0] hold_floor = {acoustic_ctrl_one_reg[HOLD_C_BIT],
                             acoustic_ctrl_one_reg[HOLD_B_BIT],
                             acoustic_ctrl_one_reg[HOLD_A_BIT]};
    wire [2:0] ramp_en = {acoustic_ctrl_two_reg[RAMP_EN_C_BIT],  // R8
                          acoustic_ctrl_two_reg[RAMP_EN_B_BIT],  // R8
                          acoustic_ctrl_one_reg[RAMP_EN_A_BIT]}; // R7
    wire [2:0][2:0] ramp_rate;
    assign ramp_rate[0] = acoustic_ctrl_one_reg[RATE_A_LSB +: 3]; // R14
    assign ramp_rate[1] = acoustic_ctrl_two_reg[RATE_B_LSB +: 3]; // R16
    assign ramp_rate[2] = acoustic_ctrl_two_reg[RATE_C_LSB +: 3]; // R15

    // channel order: remote one, local, remote two
    wire [2:0][3:0] turn_off_hysteresis;
    assign turn_off_hysteresis[0] = hyst_r1_loc_reg[HYST_HI_LSB +: 4]; // R2
    assign turn_off_hysteresis[1] = hyst_r1_loc_reg[HYST_LO_LSB +: 4]; // R2
    assign turn_off_hysteresis[2] = hyst_r2_reg;                       // R3

    wire crit_any = |crit_reg;

    // ****************************************
    // bus handshake
    // ****************************************
    // read data are latched in the wait cycle so they stand at the answering edge
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
            if (avs_read_i && !ack_reg) begin
                rdata_reg <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ****************************************
    // writable registers
    // ****************************************
    // only byte lane 0 carries data; upper lanes are ignored
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            acoustic_ctrl_one_reg <= ACOUSTIC_RST;
            acoustic_ctrl_two_reg <= ACOUSTIC_RST;
            hyst_r1_loc_reg <= HYST_R1_LOC_RST;   // R1
            hyst_r2_reg <= HYST_R2_RST[7:4];      // R1
            floor_duty_reg <= {3{FLOOR_RST}};     // R19
        end else if (wr_low) begin
            if (hit_ac_one) begin
                acoustic_ctrl_one_reg <= wr_byte;
            end
            if (hit_ac_two) begin
                acoustic_ctrl_two_reg <= wr_byte;
            end
            if (hit_hyst_one) begin
                hyst_r1_loc_reg <= wr_byte;       // R2
            end
            if (hit_hyst_two) begin
                hyst_r2_reg <= wr_byte[7:4];      // R3
            end
            if (hit_floor_a) begin
                floor_duty_reg[0] <= wr_byte;     // R19
            end
            if (hit_floor_b) begin
                floor_duty_reg[1] <= wr_byte;     // R19
            end
            if (hit_floor_c) begin
                floor_duty_reg[2] <= wr_byte;     // R19
            end
        end
    end

    // ****************************************
    // per-channel hysteresis and critical tracking
    // ****************************************
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch++) begin : g_chan
            // nine-bit sums avoid wrap near full scale
            wire [8:0] temp_w = {1'b0, chan_i[ch].temp};
            wire [8:0] on_w = {1'b0, chan_i[ch].fan_on_temp};
            wire [8:0] lim_w = {1'b0, chan_i[ch].crit_limit};
            wire [8:0] hyst_w = {5'h00, turn_off_hysteresis[ch]};
            wire drop_below = (temp_w + hyst_w) < on_w;                // R4
            wire rise_above = temp_w >= on_w;
            wire crit_enter = temp_w > lim_w;                          // R20
            wire crit_leave = (temp_w + {1'b0, CRIT_HYST}) < lim_w;    // R20

            // flags move only on a new reading; between the two points they hold
            always_ff @(posedge sys_clk_i) begin
                if (!rstn_i) begin
                    below_off_reg[ch] <= 1'b1;
                    crit_reg[ch] <= 1'b0;
                end else if (chan_i[ch].update) begin
                    if (drop_below) begin
                        below_off_reg[ch] <= 1'b1;                     // R4
                    end else if (rise_above) begin
                        below_off_reg[ch] <= 1'b0;
                    end
                    if (crit_enter) begin
                        crit_reg[ch] <= 1'b1;                          // R20
                    end else if (crit_leave) begin
                        crit_reg[ch] <= 1'b0;                          // R20
                    end
                end
            end
        end
    endgenerate

    assign crit_active_o = crit_reg;

    // ****************************************
    // slot timing shared by all outputs
    // ****************************************
    // one slot is SLOT_CYC clocks; 255 slots make one period
    wire slot_end = prescale_reg == SLOT_LAST;
    wire period_end = slot_end && (slot_reg == SLOTS_LAST);

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            prescale_reg <= '0;
            slot_reg <= 8'h00;
        end else begin
            prescale_reg <= slot_end ? '0 : prescale_reg + 1'b1;
            if (period_end) begin
                slot_reg <= 8'h00;                                     // R10
            end else if (slot_end) begin
                slot_reg <= slot_reg + 8'h01;
            end
        end
    end

    // ****************************************
    // per-output target, ramp and pwm
    // ****************************************
    genvar fo;
    generate
        for (fo = 0; fo < 3; fo++) begin : g_out
            wire fhr_src_t src = src_sel_i[fo];
            wire src_ok = src != 2'b11;
            // a new reading of the driving channel is the only ramp tick
            wire tick = src_ok & chan_i[src].update;                   // R22
            wire is_off = src_ok & below_off_reg[src];
            // below the turn-off point: floor when held, else off
            wire [7:0] tgt = !is_off ? target_duty_i[fo] :
                             hold_floor[fo] ? floor_duty_reg[fo] :     // R5
                             DUTY_OFF;                                 // R4
            wire [7:0] step = RAMP_STEP_LUT[ramp_rate[fo]];            // R14
            wire [7:0] prev = duty_reg[fo];
            wire go_up = tgt > prev;
            wire go_down = tgt < prev;
            wire [7:0] gap_up = tgt - prev;
            wire [7:0] gap_down = prev - tgt;
            // a step larger than the gap lands on the target exactly
            wire [7:0] up_val = (gap_up < step) ? tgt : prev + step;       // R11 R21
            wire [7:0] down_val = (gap_down < step) ? tgt : prev - step;   // R12 R21
            wire [7:0] ramp_val = go_up ? up_val : go_down ? down_val : prev; // R21
            wire [7:0] duty_next = ramp_en[fo] ? ramp_val : tgt;       // R6 R9
            // critical override bypasses the ramp so cooling is immediate
            wire [7:0] drive = crit_any ? DUTY_FULL : prev;            // R20
            wire pin_next = (drive == DUTY_FULL) | (slot_reg < drive); // R10

            always_ff @(posedge sys_clk_i) begin
                if (!rstn_i) begin
                    duty_reg[fo] <= DUTY_RST;
                    fan_pin_reg[fo] <= 1'b0;
                end else begin
                    if (tick) begin
                        duty_reg[fo] <= duty_next;                     // R13
                    end
                    fan_pin_reg[fo] <= pin_next;
                end
            end
        end
    endgenerate

    // spin-up lives outside; software keeps it off for ramped outputs  R18
    // swing time = 255 / step x reading interval, e.g. 35 s at one slot  R17
    assign fan_out_a_o = fan_pin_reg[0];
    assign fan_out_b_o = fan_pin_reg[1];
    assign fan_out_c_o = fan_pin_reg[2];

endmodule : fhr_fan_ctrl

// ===== sim/fhr_fan_model.sv
// partner model: three pwm fans that integrate their drive high time
`timescale 1ns/1ns
module fhr_fan_model (
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic [2:0] pin_i,
    output int cnt_o [3]
);
    // a fan follows average drive, so it only sums high clocks
    always @(posedge clk_i) begin
        for (int k = 0; k < 3; k++) begin
            cnt_o[k] <= clr_i ? 0 : cnt_o[k] + int'(pin_i[k]);
        end
    end
endmodule : fhr_fan_model

// ===== sim/fhr_fan_ctrl_sva.sv
// concurrent checks on the ports of the fan hysteresis and ramp block
`timescale 1ns/1ns
module fhr_fan_ctrl_sva
    import fhr_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire fhr_chan_s [2:0] chan_i,
    input wire logic fan_out_a_o,
    input wire logic fan_out_b_o,
    input wire logic fan_out_c_o,
    input wire logic [2:0] crit_active_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    wire req = avs_read_i | avs_write_i; // any bus request
    wire upd0 = chan_i[0].update; // new reading on remote one
    wire [8:0] temp_p4 = {1'b0, chan_i[0].temp} + 9'h004; // widened, no wrap near 0xFF
    property p_wait_first;
        $rose(req) |-> avs_waitrequest_o;
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("no wait state on new request");
    property p_one_wait;
        req && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("more than one wait state");
    property p_wait_idle;
        !req |-> !avs_waitrequest_o;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("waitrequest without request");
    property p_rdata_hi;
        avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000;
    endproperty
    a_rdata_hi: assert property (p_rdata_hi) else $error("upper read data not zero");
    property p_crit_set;
        upd0 && chan_i[0].temp > chan_i[0].crit_limit |=> crit_active_o[0];
    endproperty
    a_crit_set: assert property (p_crit_set) else $error("critical flag not set");
    property p_crit_clr;
        upd0 && temp_p4 < {1'b0, chan_i[0].crit_limit} |=> !crit_active_o[0];
    endproperty
    a_crit_clr: assert property (p_crit_clr) else $error("critical flag not cleared");
    property p_crit_hold;
        !upd0 |=> $stable(crit_active_o[0]);
    endproperty
    a_crit_hold: assert property (p_crit_hold) else $error("critical flag moved without reading");
    property p_crit_pins;
        (|crit_active_o) && $past(|crit_active_o) |-> fan_out_a_o && fan_out_b_o && fan_out_c_o;
    endproperty
    a_crit_pins: assert property (p_crit_pins) else $error("fans not full while critical");
    c_write: cover property (avs_write_i && !avs_waitrequest_o);
    c_read: cover property (avs_read_i && !avs_waitrequest_o);
    c_crit: cover property ($rose(crit_active_o[0]));
endmodule : fhr_fan_ctrl_sva

bind fhr_fan_ctrl fhr_fan_ctrl_sva u_sva (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .chan_i(chan_i),
    .fan_out_a_o(fan_out_a_o),
    .fan_out_b_o(fan_out_b_o),
    .fan_out_c_o(fan_out_c_o),
    .crit_active_o(crit_active_o)
);

// ===== sim/fhr_fan_ctrl_tb.sv
// self-checking bench with a behavioural model of the fan block
`timescale 1ns/1ns
module fhr_fan_ctrl_tb import fhr_pkg::*; ;
    // ****************************************
    // stimulus, model state
    // ****************************************
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [9:0] avs_addr = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_wdata = 32'h00000000;
    logic [3:0] avs_be = 4'h0;
    logic [31:0] avs_rdata;
    logic avs_wait;
    fhr_chan_s [2:0] chan = '0;
    fhr_src_t [2:0] src = '0;
    logic [2:0][7:0] tgt = '0;
    logic pin_a, pin_b, pin_c, fan_clr = 1'b0;
    logic [2:0] crit_o;
    int cnt [3];
    int duty [3] = '{255, 255, 255}; // reset duty is full
    int below [3] = '{1, 1, 1}; // reset as below the off point
    int crit [3] = '{0, 0, 0};
    int fl [3] = '{128, 128, 128};
    logic [7:0] ac1 = 8'h00, ac2 = 8'h00, hy1 = 8'h44, hy2 = 8'h40;
    int steps [8] = '{1, 2, 3, 5, 8, 12, 24, 48};
    logic [7:0] idx_list [12] = '{8'h30, 8'h31, 8'h32, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h6D, 8'h6E, 8'h00, 8'h7F};
    int seed = 29817;
    int x;
    int num_errors = 0;
    int tests_run = 0;
    fhr_fan_ctrl uut (.sys_clk_i(sys_clk), .rstn_i(rstn), .avs_address_i(avs_addr), .avs_read_i(avs_read),
        .avs_write_i(avs_write), .avs_writedata_i(avs_wdata), .avs_byteenable_i(avs_be),
        .avs_readdata_o(avs_rdata), .avs_waitrequest_o(avs_wait), .chan_i(chan), .src_sel_i(src),
        .target_duty_i(tgt), .fan_out_a_o(pin_a), .fan_out_b_o(pin_b), .fan_out_c_o(pin_c), .crit_active_o(crit_o));
    fhr_fan_model u_fan (.clk_i(sys_clk), .clr_i(fan_clr), .pin_i({pin_c, pin_b, pin_a}), .cnt_o(cnt));
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // holds the request until waitrequest is sampled low at a rising edge, then releases at that edge
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] b,
                       output logic [31:0] rd);
        @(posedge sys_clk);
        avs_write <= w;
        avs_read <= !w;
        avs_addr <= {idx, 2'b00};
        avs_wdata <= {24'($random(seed)), d};
        avs_be <= b;
        // no wait count assumed: a slave that never answers is ended by the watchdog
        do begin
            @(posedge sys_clk);
        end while (avs_wait !== 1'b0);
        rd = avs_rdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    // writes without lane 0, to read-only or unmapped places leave the model alone
    task automatic wreg(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] b);
        logic [31:0] rd;
        bus(1'b1, idx, d, b, rd);
        if (b[0]) begin
            case (idx)
                IDX_ACOUSTIC_ONE: ac1 = d;
                IDX_ACOUSTIC_TWO: ac2 = d;
                IDX_FLOOR_A, IDX_FLOOR_B, IDX_FLOOR_C: fl[idx - IDX_FLOOR_A] = d;
                IDX_HYST_R1_LOC: hy1 = d;
                IDX_HYST_R2: hy2 = {d[7:4], 4'h0};
                default: ;
            endcase
        end
    endtask : wreg
    function automatic logic [7:0] expv(input logic [7:0] idx);
        case (idx)
            IDX_DUTY_A, IDX_DUTY_B, IDX_DUTY_C: return 8'(duty[idx - IDX_DUTY_A]);
            IDX_ACOUSTIC_ONE: return ac1;
            IDX_ACOUSTIC_TWO: return ac2;
            IDX_FLOOR_A, IDX_FLOOR_B, IDX_FLOOR_C: return 8'(fl[idx - IDX_FLOOR_A]);
            IDX_HYST_R1_LOC: return hy1;
            IDX_HYST_R2: return hy2;
            default: return 8'h00;
        endcase
    endfunction : expv
    task automatic rreg(input logic [7:0] idx);
        logic [31:0] rd;
        bus(1'b0, idx, 8'h00, 4'hF, rd);
        check(rd, {24'h000000, expv(idx)});
    endtask : rreg
    // one reading on a channel; the model steps outputs with the flag from before it
    task automatic upd(input int ch, input int tp, input int on, input int lim);
        int h, t, st, hold, en, r;
        @(posedge sys_clk);
        chan[ch] <= '{tp[7:0], on[7:0], lim[7:0], 1'b1};
        @(posedge sys_clk);
        chan[ch].update <= 1'b0;
        for (int o = 0; o < 3; o++) begin
            if (src[o] == ch) begin
                hold = ac1[5 + o];
                en = (o == 0) ? ac1[3] : (o == 1) ? ac2[7] : ac2[3];
                r = (o == 0) ? ac1[2:0] : (o == 1) ? ac2[6:4] : ac2[2:0];
                t = below[ch] ? (hold ? fl[o] : 0) : tgt[o];
                st = en ? steps[r] : 256;
                if (t > duty[o]) duty[o] = (t - duty[o] < st) ? t : duty[o] + st;
                else if (t < duty[o]) duty[o] = (duty[o] - t < st) ? t : duty[o] - st;
            end
        end
        h = (ch == 0) ? hy1[7:4] : (ch == 1) ? hy1[3:0] : hy2[7:4];
        if (tp + h < on) below[ch] = 1;
        else if (tp >= on) below[ch] = 0;
        if (tp > lim) crit[ch] = 1;
        else if (tp + 4 < lim) crit[ch] = 0;
        @(negedge sys_clk);
        check(crit_o[ch], crit[ch]);
        for (int o = 0; o < 3; o++) rreg(8'(IDX_DUTY_A + o));
    endtask : upd
    task automatic print_verdict();
        $display("errors=%0d comparisons=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        foreach (idx_list[i]) rreg(idx_list[i]);
        wreg(IDX_HYST_R2, 8'hF5, 4'h1);
        rreg(IDX_HYST_R2);
        // every rate code; a ramps only on odd codes, so one channel drives unlike ramps
        for (int r = 0; r < 8; r++) begin
            wreg(IDX_ACOUSTIC_ONE, 8'((r % 2) * 8 + r), 4'hF);
            wreg(IDX_ACOUSTIC_TWO, 8'(8'h88 + r * 17), 4'hF);
            tgt <= {8'(r * 30), 8'(255 - r * 30), 8'(r * 37)};
            upd(0, 60, 50, 100);
            upd(0, 60, 50, 100);
        end
        // random configuration, sources, targets and readings around the hysteresis band
        for (int i = 0; i < 60; i++) begin
            x = $random(seed);
            wreg(IDX_ACOUSTIC_ONE, 8'($random(seed)), 4'h1);
            wreg(IDX_ACOUSTIC_TWO, 8'($random(seed)), 4'h1);
            wreg(idx_list[$unsigned(x) % 12], 8'($random(seed)), 4'($random(seed)));
            src <= 6'($random(seed));
            tgt <= 24'($random(seed));
            upd(($unsigned(x) >> 8) % 3, 30 + ($unsigned(x) >> 12) % 100, 50, 100);
        end
        // pin high time over one whole period, critical cleared on every channel
        wreg(IDX_ACOUSTIC_ONE, 8'h00, 4'h1);
        wreg(IDX_ACOUSTIC_TWO, 8'h00, 4'h1);
        src <= '0;
        tgt <= {8'hFF, 8'h00, 8'h55};
        for (int c = 0; c < 3; c++) upd(c, 60, 50, 200);
        upd(0, 60, 50, 200);
        repeat (10) @(posedge sys_clk);
        fan_clr <= 1'b1;
        @(posedge sys_clk);
        fan_clr <= 1'b0;
        repeat (25500) @(posedge sys_clk);
        @(negedge sys_clk);
        for (int o = 0; o < 3; o++) check(cnt[o], (duty[o] == 255) ? 25500 : duty[o] * SLOT_CYC);
        print_verdict();
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        num_errors++;
        print_verdict();
    end
endmodule : fhr_fan_ctrl_tb
